/* caf_router.sv */
// acceptance filter routing with filter and fifo control registers
//
// Function
// - filter matches only while its enable is one
// - mask choice 00/01/10 picks mask 0/1/2
// - match goes to fifo named by destination
// - mask choice and destination locked while filter enabled
// - word two: filter nine upper, eight lower
// - word three: filter thirteen upper, twelve lower
// - sixteen fifo words, depth at 20-16
// - fifo holds depth field plus one messages
// - depth writable only in configuration mode
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "caf_cfg.svh"
module caf_router #(
    parameter int ID_W = 29
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`CAF_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rd_data_o,
    input wire logic msg_valid_i,
    input wire logic [ID_W-1:0] msg_id_i,
    output logic route_valid_o,
    output caf_pkg::caf_dest_t route_fifo_o,
    output caf_pkg::caf_fnum_t route_filter_o,
    output caf_pkg::caf_depth_t route_depth_o,
    output caf_pkg::caf_mode_t op_mode_o
);
    import caf_pkg::*;

    typedef struct packed {
        logic [3:0] en;
        logic [3:0][1:0] msel;
        logic [3:0][4:0] dest;
        logic [3:0][ID_W-1:0] fid;
        logic [2:0][ID_W-1:0] mask;
        logic [2:0] mode;
        logic [15:0][4:0] depth;
        logic [31:0] rd_data;
        logic rt_valid;
        logic [4:0] rt_fifo;
        logic [3:0] rt_filter;
        logic [5:0] rt_depth;
    } caf_state_t;

    caf_state_t q;
    caf_state_t d;
    logic [3:0] hit;
    logic fifo_sel;
    logic [3:0] fifo_idx;

    assign fifo_sel = (addr_i[7:6] == 2'h1) && (addr_i[1:0] == 2'h0);
    assign fifo_idx = addr_i[5:2];

    // ============================================================
    // filter slots: index 0..3 are filters 8, 9, 12, 13
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_slot
            caf_filter_slot #(.ID_W(ID_W)) u_slot (
                .en_i(q.en[g]),
                .msel_i(q.msel[g]),
                .filt_id_i(q.fid[g]),
                .mask0_i(q.mask[0]),
                .mask1_i(q.mask[1]),
                .mask2_i(q.mask[2]),
                .msg_id_i(msg_id_i),
                .hit_o(hit[g])
            );
        end
    endgenerate

    // ============================================================
    // next state
    always_comb
    begin
        logic [7:0] fb;
        logic [1:0] win;
        logic [4:0] dst;
        fb = '0;
        win = '0;
        dst = '0;
        d = q;
        d.rd_data = '0;
        d.rt_valid = 1'b0;
        // register writes
        if (we_i)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (addr_i == ((k < 2) ? `CAF_OFS_FLT_TWO : `CAF_OFS_FLT_THREE))
                begin
                    fb = wdata_i[8*(k%2) +: 8];
                    d.en[k] = fb[`CAF_FLT_ON_BIT];
                    if (!q.en[k])
                    begin
                        d.msel[k] = fb[6:5];
                        d.dest[k] = fb[4:0];
                    end
                end
                if (addr_i == `CAF_OFS_FID_BASE + 8'(4 * k))
                    d.fid[k] = wdata_i[ID_W-1:0];
            end
            for (int m = 0; m < 3; m++)
            begin
                if (addr_i == `CAF_OFS_MASK0 + 8'(4 * m))
                    d.mask[m] = wdata_i[ID_W-1:0];
            end
            if (addr_i == `CAF_OFS_MODE)
                d.mode = wdata_i[2:0];
            if (fifo_sel && q.mode == `CAF_MODE_CONFIG)
                d.depth[fifo_idx] = wdata_i[`CAF_DEPTH_MSB:`CAF_DEPTH_LSB];
        end
        // register reads, data in the next cycle only
        if (re_i)
        begin
            if (addr_i == `CAF_OFS_FLT_TWO)
                d.rd_data = {16'h0000, q.en[1], q.msel[1], q.dest[1],
                             q.en[0], q.msel[0], q.dest[0]};
            else if (addr_i == `CAF_OFS_FLT_THREE)
                d.rd_data = {16'h0000, q.en[3], q.msel[3], q.dest[3],
                             q.en[2], q.msel[2], q.dest[2]};
            else if (addr_i == `CAF_OFS_MODE)
                d.rd_data = {29'h0, q.mode};
            else if (fifo_sel)
                d.rd_data = {11'h000, q.depth[fifo_idx], 16'h0000};
            for (int k = 0; k < 4; k++)
            begin
                if (addr_i == `CAF_OFS_FID_BASE + 8'(4 * k))
                    d.rd_data = 32'(q.fid[k]);
            end
            for (int m = 0; m < 3; m++)
            begin
                if (addr_i == `CAF_OFS_MASK0 + 8'(4 * m))
                    d.rd_data = 32'(q.mask[m]);
            end
        end
        // routing: lowest filter index wins
        for (int k = 3; k >= 0; k--)
        begin
            if (hit[k])
                win = 2'(k);
        end
        if (msg_valid_i && (|hit))
        begin
            dst = q.dest[win];
            d.rt_valid = 1'b1;
            d.rt_fifo = dst;
            d.rt_filter = {1'b1, win[1], 1'b0, win[0]};
            if (dst < 5'(`CAF_FIFO_REGS))
                d.rt_depth = {1'b0, q.depth[dst[3:0]]} + 6'h01;
            else
                d.rt_depth = 6'h00;
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.mode <= `CAF_MODE_RST;
        end
        else
            q <= d;
    end

    assign rd_data_o = q.rd_data;
    assign route_valid_o = q.rt_valid;
    assign route_fifo_o = q.rt_fifo;
    assign route_filter_o = q.rt_filter;
    assign route_depth_o = q.rt_depth;
    assign op_mode_o = q.mode;

    // ============================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    filt_off_a: assert property (msg_valid_i && q.en == 4'h0 |=> !route_valid_o)
        else $error("disabled filters produced a route");
    mask_rsv_a: assert property (msg_valid_i && q.en[0] && q.msel[0] == 2'h3
                                 |=> !(route_valid_o && route_filter_o == 4'h8))
        else $error("reserved mask choice matched");
    dest_route_a: assert property (msg_valid_i && hit[0]
                                   |=> route_valid_o && route_fifo_o == $past(q.dest[0]))
        else $error("route fifo differs from filter destination");
    filt_lock_a: assert property (we_i && addr_i == `CAF_OFS_FLT_TWO && q.en[1]
                                  |=> $stable(q.msel[1]) && $stable(q.dest[1]))
        else $error("locked filter settings changed");
    word_two_a: assert property (re_i && addr_i == `CAF_OFS_FLT_TWO
                                 |=> rd_data_o[14:13] == $past(q.msel[1]))
        else $error("filter nine mask choice misplaced");
    word_three_a: assert property (re_i && addr_i == `CAF_OFS_FLT_THREE
                                   |=> rd_data_o[15] == $past(q.en[3]))
        else $error("filter thirteen enable misplaced");
    fifo_zero_a: assert property (re_i && fifo_sel |=> rd_data_o[31:21] == 11'h000)
        else $error("fifo word upper bits not zero");
    depth_plus_a: assert property (route_valid_o && route_fifo_o < 5'h10 && $stable(q.depth)
                                   |-> route_depth_o ==
                                       {1'b0, q.depth[route_fifo_o[3:0]]} + 6'h01)
        else $error("fifo depth not field plus one");
    depth_lock_a: assert property (we_i && fifo_sel && q.mode != `CAF_MODE_CONFIG
                                   |=> $stable(q.depth))
        else $error("depth written outside configuration mode");
    prio_a: assert property (msg_valid_i && hit[1] && !hit[0]
                             |=> route_filter_o == 4'h9)
        else $error("wrong filter won");
endmodule

/* caf_cfg.svh */
// register offsets, field positions, reset values for the acceptance filter router
`ifndef CAF_CFG_SVH
`define CAF_CFG_SVH

// ============================================================
// register offsets (byte addresses)
`define CAF_ADDR_W 8
`define CAF_OFS_FLT_TWO 8'h00
`define CAF_OFS_FLT_THREE 8'h04
`define CAF_OFS_MODE 8'h08
`define CAF_OFS_MASK0 8'h10
`define CAF_OFS_MASK1 8'h14
`define CAF_OFS_MASK2 8'h18
`define CAF_OFS_FID_BASE 8'h20
`define CAF_OFS_FIFO_BASE 8'h40

// ============================================================
// field positions and codes
`define CAF_FLT_ON_BIT 7
`define CAF_DEPTH_LSB 16
`define CAF_DEPTH_MSB 20
`define CAF_MODE_CONFIG 3'h4
`define CAF_MODE_RST 3'h4
`define CAF_MSEL_RSV 2'h3
`define CAF_FIFO_REGS 16

`endif

/* caf_pkg.sv */
// types shared by the acceptance filter router
package caf_pkg;
    typedef logic [1:0] caf_msel_t;
    typedef logic [4:0] caf_dest_t;
    typedef logic [2:0] caf_mode_t;
    typedef logic [3:0] caf_fnum_t;
    typedef logic [5:0] caf_depth_t;
endpackage

/* caf_filter_slot.sv */
// one acceptance filter: enable, mask choice and id compare
`timescale 1ns/1ps
`include "caf_cfg.svh"
module caf_filter_slot #(
    parameter int ID_W = 29
) (
    input wire logic en_i,
    input wire caf_pkg::caf_msel_t msel_i,
    input wire logic [ID_W-1:0] filt_id_i,
    input wire logic [ID_W-1:0] mask0_i,
    input wire logic [ID_W-1:0] mask1_i,
    input wire logic [ID_W-1:0] mask2_i,
    input wire logic [ID_W-1:0] msg_id_i,
    output logic hit_o
);
    import caf_pkg::*;

    logic [ID_W-1:0] mask;
    logic valid_sel;

    // ============================================================
    // mask choice
    always_comb
    begin
        mask = '0;
        valid_sel = 1'b1;
        case (msel_i)
            2'h0: mask = mask0_i;
            2'h1: mask = mask1_i;
            2'h2: mask = mask2_i;
            default: valid_sel = 1'b0;
        endcase
    end

    // masked bits compare; disabled filter never hits
    assign hit_o = en_i && valid_sel && (((msg_id_i ^ filt_id_i) & mask) == '0);
endmodule

/* caf_msg_src.sv */
// far-side message source standing in for the protocol engine
`timescale 1ns/1ps
module caf_msg_src #(
    parameter int ID_W = 29
) (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [ID_W-1:0] id_i,
    output logic msg_valid_o = 1'h0,
    output logic [ID_W-1:0] msg_id_o = '0
);
    // ============================================================
    // one-cycle message; id inverts while idle so no stale id is seen
    always_ff @(posedge clk_i)
    begin
        msg_valid_o <= send_i;
        msg_id_o <= send_i ? id_i : ~msg_id_o;
    end
endmodule

/* caf_router_test.sv */
// self-checking bench for the acceptance filter router
`timescale 1ns/1ps
`include "caf_cfg.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module caf_router_test;
    import caf_pkg::*;
    logic clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, re_i = 1'h0, send = 1'h0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rd_data_o;
    logic [28:0] tx_id = 29'h0, msg_id;
    logic msg_valid, route_valid_o;
    caf_dest_t route_fifo_o;
    caf_fnum_t route_filter_o;
    caf_depth_t route_depth_o;
    caf_mode_t op_mode_o;
    int mismatches = 0, tests_run = 0, cycles = 0;
    // ============================================================
    // design and far side
    caf_router dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rd_data_o(rd_data_o), .msg_valid_i(msg_valid),
        .msg_id_i(msg_id), .route_valid_o(route_valid_o), .route_fifo_o(route_fifo_o),
        .route_filter_o(route_filter_o), .route_depth_o(route_depth_o),
        .op_mode_o(op_mode_o));
    caf_msg_src src (.clk_i(clk_i), .send_i(send), .id_i(tx_id),
        .msg_valid_o(msg_valid), .msg_id_o(msg_id));
    // ============================================================
    // bus and message tasks
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'h1;
        @(posedge clk_i);
        we_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'h1;
        @(posedge clk_i);
        re_i <= 1'h0;
        @(negedge clk_i);
        `CHK("rd_data_o", e, rd_data_o)
    endtask
    task msg(input logic [28:0] id, input logic v, input caf_fnum_t f, input caf_dest_t q,
        input caf_depth_t dp);
        @(posedge clk_i);
        send <= 1'h1;
        tx_id <= id;
        @(posedge clk_i);
        send <= 1'h0;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK("route_valid_o", v, route_valid_o)
        if (v)
            `CHK("route", {f, q, dp}, {route_filter_o, route_fifo_o, route_depth_o})
    endtask
    // ============================================================
    // scenarios
    task t_reset;
        @(negedge clk_i);
        `CHK("op_mode_o", `CAF_MODE_RST, op_mode_o)
        rd(8'h00, 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h0C, 32'h0);
    endtask
    task t_basic;
        wr(8'h10, 32'h1FFF_FFFF);
        wr(8'h18, 32'h1FFF_FF00);
        wr(8'h20, 32'h100);
        wr(8'h24, 32'h200);
        wr(8'h28, 32'h300);
        wr(8'h2C, 32'h400);
        wr(8'h00, 32'h85);
        rd(8'h00, 32'h85);
        msg(29'h100, 1'h1, 4'h8, 5'h05, 6'h01);
        msg(29'h101, 1'h0, 4'h0, 5'h00, 6'h00);
    endtask
    task t_lock;
        wr(8'h00, 32'hBF);
        rd(8'h00, 32'h85);
        wr(8'h00, 32'h05);
        msg(29'h100, 1'h0, 4'h0, 5'h00, 6'h00);
        wr(8'h00, 32'h3F);
        wr(8'h00, 32'hBF);
        rd(8'h00, 32'hBF);
        msg(29'h123, 1'h1, 4'h8, 5'h1F, 6'h00);
    endtask
    task t_upper;
        wr(8'h00, 32'hC300);
        rd(8'h00, 32'hC33F);
        msg(29'h2AB, 1'h1, 4'h9, 5'h03, 6'h01);
        wr(8'h04, 32'hE2);
        msg(29'h300, 1'h0, 4'h0, 5'h00, 6'h00);
        wr(8'h04, 32'h8600);
        rd(8'h04, 32'h8662);
        msg(29'h400, 1'h1, 4'hD, 5'h06, 6'h01);
    endtask
    task t_depth;
        wr(8'h58, 32'hFFFF_FFFF);
        rd(8'h58, 32'h001F_0000);
        msg(29'h400, 1'h1, 4'hD, 5'h06, 6'h20);
        wr(8'h7C, 32'h0002_0000);
        rd(8'h7C, 32'h0002_0000);
        wr(8'h08, 32'h0);
        @(negedge clk_i);
        `CHK("op_mode_o", 3'h0, op_mode_o)
        wr(8'h58, 32'h0);
        rd(8'h58, 32'h001F_0000);
    endtask
    task t_prio;
        wr(8'h00, 32'hC3BF);
        msg(29'h400, 1'h1, 4'h8, 5'h1F, 6'h00);
    endtask
    // ============================================================
    // verdict, clock, watchdog and main sequence
    task summarize;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_basic();
        t_lock();
        t_upper();
        t_depth();
        t_prio();
        summarize();
    end
endmodule
